// ### rtl/iser_defs.vh
`ifndef ISER_DEFS_VH
`define ISER_DEFS_VH

// ==========================================================================
// Command codes on the command port.
`define ISER_CMD_CLS 4'h0
`define ISER_CMD_ESE_W 4'h1
`define ISER_CMD_ESE_Q 4'h2
`define ISER_CMD_ESR_Q 4'h3
`define ISER_CMD_OPC 4'h4
`define ISER_CMD_OPC_Q 4'h5
`define ISER_CMD_PSC_W 4'h6
`define ISER_CMD_PSC_Q 4'h7
`define ISER_CMD_SRE_W 4'h8
`define ISER_CMD_SRE_Q 4'h9
`define ISER_CMD_STB_Q 4'hA
`define ISER_CMD_QEN_W 4'hB
`define ISER_CMD_QEN_Q 4'hC
`define ISER_CMD_QEV_Q 4'hD
`define ISER_CMD_PRESET 4'hE
`define ISER_CMD_ERR_Q 4'hF

// ==========================================================================
// Standard event latch bit positions, implemented bits and reset value.
`define ISER_SE_OPC 0
`define ISER_SE_QYE 2
`define ISER_SE_DDE 3
`define ISER_SE_EXE 4
`define ISER_SE_CME 5
`define ISER_SE_PON 7
`define ISER_SE_USED 8'hBD
`define ISER_SE_RESET 8'h80

// ==========================================================================
// Questionable event latch bit positions and implemented bits.
`define ISER_QB_VOLT 0
`define ISER_QB_CURR 1
`define ISER_QB_OHMS 9
`define ISER_QB_LIM_LO 11
`define ISER_QB_LIM_HI 12
`define ISER_QB_USED 16'h1A03

// Overload kinds on the overload kind input.
`define ISER_OVL_VOLT 2'h0
`define ISER_OVL_CURR 2'h1
`define ISER_OVL_OHMS 2'h2

// ==========================================================================
// Status byte bit positions and writable service request enable bits.
`define ISER_SB_QSUM 3
`define ISER_SB_MAV 4
`define ISER_SB_ESB 5
`define ISER_SB_RQS 6
`define ISER_SRE_WMASK 8'hBF

// ==========================================================================
// Error queue geometry and the empty answer.
`define ISER_EQ_DEPTH 5'h14
`define ISER_EQ_LAST 5'h13
`define ISER_EQ_AW 5
`define ISER_EQ_DW 16
`define ISER_ERR_STR_MAX 80
`define ISER_ERR_NONE 16'h0000
`define ISER_OPC_REPLY 16'h0001

`endif

// ### rtl/iser_err_mem.v
`timescale 1ns/1ps
`include "iser_defs.vh"

// ==========================================================================
// Error queue storage: one write port, one read port, registered read data.
module iser_err_mem (
  input wire i_sys_clk,
  input wire i_clk_en,
  input wire i_we,
  input wire [`ISER_EQ_AW-1:0] i_waddr,
  input wire [`ISER_EQ_DW-1:0] i_wdata,
  input wire i_re,
  input wire [`ISER_EQ_AW-1:0] i_raddr,
  output reg [`ISER_EQ_DW-1:0] o_rdata
);

  reg [`ISER_EQ_DW-1:0] mem [0:`ISER_EQ_LAST];

  // Storage has no reset; only the read register is defined at start-up.
  always @(posedge i_sys_clk) begin
    if (i_clk_en && i_we) begin
      mem[i_waddr] <= i_wdata;
    end
  end

  // Read data comes out of a register one cycle after the read strobe.
  initial o_rdata = `ISER_ERR_NONE;
  always @(posedge i_sys_clk) begin
    if (i_clk_en && i_re) begin
      o_rdata <= mem[i_raddr];
    end
  end

endmodule

// ### rtl/iser_status.v
`timescale 1ns/1ps
`include "iser_defs.vh"

module iser_status (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_clk_en,
  input wire i_cmd_valid,
  input wire [3:0] i_cmd_code,
  input wire [15:0] i_cmd_arg,
  output reg o_cmd_ready,
  output reg o_rsp_valid,
  output reg [15:0] o_rsp_data,
  input wire i_prior_busy,
  input wire i_ev_empty_read,
  input wire i_ev_reply_overrun,
  input wire i_ev_bufs_full,
  input wire i_ev_dev_err,
  input wire i_ev_exec_err,
  input wire i_ev_cmd_err,
  input wire [15:0] i_err_code,
  input wire i_ev_overload,
  input wire [1:0] i_ovl_kind,
  input wire i_ev_lim_lo,
  input wire i_ev_lim_hi,
  input wire i_mav,
  input wire i_rqs,
  input wire i_nv_psc,
  input wire [7:0] i_nv_ese,
  input wire [7:0] i_nv_sre,
  output reg o_psc,
  output reg [7:0] o_ese_mask,
  output reg [7:0] o_sre_mask,
  output reg [15:0] o_ques_mask,
  output reg o_std_summary,
  output reg o_ques_summary,
  output reg [7:0] o_status_byte,
  output reg o_cls_pulse,
  output reg [4:0] o_eq_count
);

  // ==========================================================================
  // Helper functions.

  // Sticky latch update: a set in the clearing cycle survives.
  function [15:0] f_merge;
    input [15:0] cur;
    input [15:0] set;
    input clr;
    begin
      f_merge = (cur & {16{~clr}}) | set;
    end
  endfunction

  // Queue pointer advance with wrap after the last slot.
  function [4:0] f_wrap;
    input [4:0] p;
    begin
      if (p == `ISER_EQ_LAST) begin
        f_wrap = 5'h00;
      end else begin
        f_wrap = p + 5'h01;
      end
    end
  endfunction

  // Overload kind to questionable bit.
  function [15:0] f_ovl_bits;
    input [1:0] kind;
    begin
      f_ovl_bits = 16'h0000;
      case (kind)
        `ISER_OVL_VOLT: f_ovl_bits[`ISER_QB_VOLT] = 1'b1;
        `ISER_OVL_CURR: f_ovl_bits[`ISER_QB_CURR] = 1'b1;
        `ISER_OVL_OHMS: f_ovl_bits[`ISER_QB_OHMS] = 1'b1;
        default: f_ovl_bits = 16'h0000;
      endcase
    end
  endfunction

  // True when the pending command runs in this cycle with the wanted code.
  function f_runs;
    input run;
    input [3:0] have;
    input [3:0] want;
    begin
      f_runs = run && (have == want);
    end
  endfunction

  // ==========================================================================
  // State.
  reg init_q;
  reg pend_q;
  reg [3:0] pcode_q;
  reg [15:0] parg_q;
  reg [7:0] sesr_q;
  reg [15:0] qev_q;
  reg [4:0] wp_q;
  reg [4:0] rp_q;
  reg err_rsp_q;
  wire [15:0] mem_rdata;

  reg exec;
  reg [7:0] se_set;
  reg se_clr;
  reg [7:0] sesr_d;
  reg [15:0] q_set;
  reg q_clr;
  reg [15:0] qev_d;
  reg [7:0] ese_d;
  reg [7:0] sre_d;
  reg [15:0] qen_d;
  reg psc_d;
  reg qye;
  reg err_any;
  reg push;
  reg pop;
  reg [4:0] cnt_d;
  reg std_sum_d;
  reg ques_sum_d;
  reg rsp_v_d;
  reg [15:0] rsp_d;
  reg pend_d;
  reg [7:0] stb_now;
  reg [7:0] stb_d;
  reg [15:0] se_merged;
  reg eq_empty;
  reg eq_full;

  // ==========================================================================
  // Next-state logic.

  // Command execution, event latching, masks, queue control and replies.
  always @* begin
    // Commands run in order, each only after all earlier work has finished.
    exec = pend_q & ~i_prior_busy & ~init_q;
    qye = i_ev_empty_read | i_ev_reply_overrun | i_ev_bufs_full;
    err_any = qye | i_ev_dev_err | i_ev_exec_err | i_ev_cmd_err;
    // Queue fill state, shared by the push, pop and empty-reply paths.
    eq_empty = (o_eq_count == 5'h00);
    eq_full = (o_eq_count == `ISER_EQ_DEPTH);

    // Standard event sources; overload lands on the device error bit.
    se_set = 8'h00;
    se_set[`ISER_SE_OPC] = f_runs(exec, pcode_q, `ISER_CMD_OPC);
    se_set[`ISER_SE_QYE] = qye;
    se_set[`ISER_SE_DDE] = i_ev_dev_err | i_ev_overload;
    se_set[`ISER_SE_EXE] = i_ev_exec_err;
    se_set[`ISER_SE_CME] = i_ev_cmd_err;
    se_clr = f_runs(exec, pcode_q, `ISER_CMD_CLS) | f_runs(exec, pcode_q, `ISER_CMD_ESR_Q);
    // Unused bits are forced to zero; the power-on bit only drops on a clear-status command or a read of the register.
    // The merge works on a full word, so only its low byte is kept.
    se_merged = f_merge({8'h00, sesr_q}, {8'h00, se_set}, se_clr);
    sesr_d = se_merged[7:0] & `ISER_SE_USED;

    // Questionable sources.
    q_set = 16'h0000;
    if (i_ev_overload) begin
      q_set = f_ovl_bits(i_ovl_kind);
    end
    q_set[`ISER_QB_LIM_LO] = i_ev_lim_lo;
    q_set[`ISER_QB_LIM_HI] = i_ev_lim_hi;
    q_clr = f_runs(exec, pcode_q, `ISER_CMD_CLS) | f_runs(exec, pcode_q, `ISER_CMD_QEV_Q);
    qev_d = f_merge(qev_q, q_set, q_clr) & `ISER_QB_USED;

    // Mask and setting writes; writing zero clears the mask.
    ese_d = o_ese_mask;
    sre_d = o_sre_mask;
    qen_d = o_ques_mask;
    psc_d = o_psc;
    if (exec) begin
      case (pcode_q)
        `ISER_CMD_ESE_W: ese_d = parg_q[7:0];
        `ISER_CMD_SRE_W: sre_d = parg_q[7:0] & `ISER_SRE_WMASK;
        `ISER_CMD_QEN_W: qen_d = parg_q;
        `ISER_CMD_PRESET: qen_d = 16'h0000;
        `ISER_CMD_PSC_W: psc_d = (parg_q != 16'h0000);
        default: ese_d = o_ese_mask;
      endcase
    end

    // Summaries follow latch and mask in the same cycle, never latched.
    std_sum_d = |(sesr_d & ese_d);
    ques_sum_d = |(qev_d & qen_d);

    // Error queue: one entry per cycle of errors, none for overload alone.
    push = err_any && !eq_full;
    pop = f_runs(exec, pcode_q, `ISER_CMD_ERR_Q) && !eq_empty;
    cnt_d = o_eq_count;
    if (push && !pop) begin
      cnt_d = o_eq_count + 5'h01;
    end else if (pop && !push) begin
      cnt_d = o_eq_count - 5'h01;
    end

    // Status byte as a serial poll would see it, request bit untouched.
    stb_now = 8'h00;
    stb_now[`ISER_SB_QSUM] = o_ques_summary;
    stb_now[`ISER_SB_MAV] = i_mav;
    stb_now[`ISER_SB_ESB] = o_std_summary;
    stb_now[`ISER_SB_RQS] = i_rqs;

    // Registered status byte, built from the summaries of this edge.
    stb_d = 8'h00;
    stb_d[`ISER_SB_QSUM] = ques_sum_d;
    stb_d[`ISER_SB_MAV] = i_mav;
    stb_d[`ISER_SB_ESB] = std_sum_d;
    stb_d[`ISER_SB_RQS] = i_rqs;

    // Replies carry the plain binary weight of the register.
    rsp_v_d = 1'b0;
    rsp_d = 16'h0000;
    if (err_rsp_q) begin
      rsp_v_d = 1'b1;
      rsp_d = mem_rdata;
    end else if (exec) begin
      rsp_v_d = 1'b1;
      case (pcode_q)
        `ISER_CMD_ESE_Q: rsp_d = {8'h00, o_ese_mask};
        `ISER_CMD_ESR_Q: rsp_d = {8'h00, sesr_q};
        `ISER_CMD_OPC_Q: rsp_d = `ISER_OPC_REPLY;
        `ISER_CMD_PSC_Q: rsp_d = {15'h0000, o_psc};
        `ISER_CMD_SRE_Q: rsp_d = {8'h00, o_sre_mask};
        `ISER_CMD_STB_Q: rsp_d = {8'h00, stb_now};
        `ISER_CMD_QEN_Q: rsp_d = o_ques_mask;
        `ISER_CMD_QEV_Q: rsp_d = qev_q;
        `ISER_CMD_ERR_Q: begin
          // A non-empty queue answers one cycle later from the memory.
          rsp_v_d = eq_empty;
          rsp_d = `ISER_ERR_NONE;
        end
        default: rsp_v_d = 1'b0;
      endcase
    end

    // One command waits at a time; it leaves when executed.
    pend_d = pend_q;
    if (exec) begin
      pend_d = 1'b0;
    end else if (i_cmd_valid && o_cmd_ready) begin
      pend_d = 1'b1;
    end
  end

  // ==========================================================================
  // Error queue storage.
  iser_err_mem u_err_mem (
    .i_sys_clk(i_sys_clk),
    .i_clk_en(i_clk_en),
    .i_we(push),
    .i_waddr(wp_q),
    .i_wdata(i_err_code),
    .i_re(pop),
    .i_raddr(rp_q),
    .o_rdata(mem_rdata)
  );

  // ==========================================================================
  // Registers.

  // Power-on reset sets the power-on bit and clears the questionable mask.
  always @(posedge i_sys_clk or posedge i_reset) begin
    if (i_reset) begin
      init_q <= 1'b1;
      pend_q <= 1'b0;
      pcode_q <= 4'h0;
      parg_q <= 16'h0000;
      sesr_q <= `ISER_SE_RESET;
      qev_q <= 16'h0000;
      wp_q <= 5'h00;
      rp_q <= 5'h00;
      err_rsp_q <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_data <= 16'h0000;
      o_psc <= 1'b0;
      o_ese_mask <= 8'h00;
      o_sre_mask <= 8'h00;
      o_ques_mask <= 16'h0000;
      o_std_summary <= 1'b0;
      o_ques_summary <= 1'b0;
      o_status_byte <= 8'h00;
      o_cls_pulse <= 1'b0;
      o_eq_count <= 5'h00;
    end else if (i_clk_en) begin
      if (init_q) begin
        // Restore the power-on clear flag once, right after power-on; the ESE and SRE masks come from nonvolatile storage only when it is clear.
        init_q <= 1'b0;
        o_psc <= i_nv_psc;
        o_ese_mask <= i_nv_psc ? 8'h00 : i_nv_ese;
        o_sre_mask <= i_nv_psc ? 8'h00 : (i_nv_sre & `ISER_SRE_WMASK);
        o_cmd_ready <= 1'b1;
      end else begin
        o_psc <= psc_d;
        o_ese_mask <= ese_d;
        o_sre_mask <= sre_d;
        // A pop holds ready low one more cycle, so the memory reply and the
        // reply of the next query never stand in adjacent cycles.
        o_cmd_ready <= ~pend_d & ~pop;
      end
      if (i_cmd_valid && o_cmd_ready) begin
        pcode_q <= i_cmd_code;
        parg_q <= i_cmd_arg;
      end
      pend_q <= pend_d;
      sesr_q <= sesr_d;
      qev_q <= qev_d;
      o_ques_mask <= qen_d;
      o_std_summary <= std_sum_d;
      o_ques_summary <= ques_sum_d;
      o_status_byte <= stb_d;
      o_cls_pulse <= f_runs(exec, pcode_q, `ISER_CMD_CLS);
      o_rsp_valid <= rsp_v_d;
      o_rsp_data <= rsp_d;
      err_rsp_q <= pop;
      o_eq_count <= cnt_d;
      if (push) begin
        wp_q <= f_wrap(wp_q);
      end
      if (pop) begin
        rp_q <= f_wrap(rp_q);
      end
    end
  end

endmodule

// ### verif/iser_status_assertions.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the status block.
module iser_chk (
  input wire i_sys_clk,
  input wire i_reset,
  input wire i_cmd_valid,
  input wire i_prior_busy,
  input wire i_ev_empty_read,
  input wire i_ev_reply_overrun,
  input wire i_ev_bufs_full,
  input wire i_ev_dev_err,
  input wire i_ev_exec_err,
  input wire i_ev_cmd_err,
  input wire i_ev_overload,
  input wire o_cmd_ready,
  input wire o_rsp_valid,
  input wire [7:0] o_ese_mask,
  input wire [15:0] o_ques_mask,
  input wire o_std_summary,
  input wire o_ques_summary,
  input wire [7:0] o_status_byte,
  input wire [4:0] o_eq_count
);
  // An idle port cannot pop the queue in the same edge.
  wire err_any = i_ev_empty_read | i_ev_reply_overrun | i_ev_bufs_full | i_ev_dev_err | i_ev_exec_err | i_ev_cmd_err;
  wire idle = o_cmd_ready & ~i_cmd_valid;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_reset);
  a_sb_map: assert property (o_status_byte[5] == o_std_summary && o_status_byte[3] == o_ques_summary
    && o_status_byte[7] == 1'b0 && o_status_byte[2:0] == 3'h0) else $error("status byte map wrong");
  a_std_sum: assert property (o_ese_mask == 8'h00 ##1 o_ese_mask == 8'h00 |-> !o_std_summary)
    else $error("std summary without mask");
  a_ques_sum: assert property (o_ques_mask == 16'h0000 ##1 o_ques_mask == 16'h0000 |-> !o_ques_summary)
    else $error("ques summary without mask");
  a_rsp_one: assert property (o_rsp_valid |=> !o_rsp_valid) else $error("reply held too long");
  a_take_drop: assert property (i_cmd_valid && o_cmd_ready |=> !o_cmd_ready) else $error("ready stayed up");
  a_busy_hold: assert property (!o_cmd_ready && i_prior_busy ##1 i_prior_busy |=> !o_rsp_valid)
    else $error("reply while busy");
  a_ovl_noq: assert property (idle && i_ev_overload && !err_any |=> o_eq_count == $past(o_eq_count))
    else $error("overload queued");
  a_err_push: assert property (idle && i_ev_cmd_err && o_eq_count < 5'h14
    |=> o_eq_count == $past(o_eq_count) + 5'h01) else $error("error not queued");
  c_full: cover property (o_eq_count == 5'h14);
  c_std: cover property (o_std_summary);
  c_busy: cover property (i_prior_busy && !o_cmd_ready);
endmodule

bind iser_status iser_chk u_chk (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_cmd_valid(i_cmd_valid),
  .i_prior_busy(i_prior_busy), .i_ev_empty_read(i_ev_empty_read), .i_ev_reply_overrun(i_ev_reply_overrun),
  .i_ev_bufs_full(i_ev_bufs_full), .i_ev_dev_err(i_ev_dev_err), .i_ev_exec_err(i_ev_exec_err),
  .i_ev_cmd_err(i_ev_cmd_err), .i_ev_overload(i_ev_overload), .o_cmd_ready(o_cmd_ready),
  .o_rsp_valid(o_rsp_valid), .o_ese_mask(o_ese_mask), .o_ques_mask(o_ques_mask), .o_std_summary(o_std_summary),
  .o_ques_summary(o_ques_summary), .o_status_byte(o_status_byte), .o_eq_count(o_eq_count));

// ### verif/iser_ctrl_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Remote controller issuing one command at a time.
module iser_ctrl_model (
  input wire i_sys_clk,
  input wire i_ready,
  input wire i_rsp_valid,
  input wire [15:0] i_rsp_data,
  output reg o_valid = 1'b0,
  output reg [3:0] o_code = 4'h0,
  output reg [15:0] o_arg = 16'h0000
);
  // Holds the request to a ready edge, then scrambles the released lines.
  task automatic xfer(input [3:0] c, input [15:0] a, input q, output [15:0] r);
    integer n;
    begin
      r = 16'hFFFF;
      @(posedge i_sys_clk);
      o_valid <= 1'b1;
      o_code <= c;
      o_arg <= a;
      @(negedge i_sys_clk);
      while (!i_ready) @(negedge i_sys_clk);
      @(posedge i_sys_clk);
      o_valid <= 1'b0;
      o_code <= ~c;
      o_arg <= ~a;
      for (n = 0; q && n < 64; n = n + 1) begin
        @(negedge i_sys_clk);
        if (i_rsp_valid) begin
          r = i_rsp_data;
          n = 64;
        end
      end
    end
  endtask
endmodule

// ### verif/tb_instrument_status_event_registers.sv
`timescale 1ns/1ps
`include "iser_defs.vh"
// ==========================================================================
// Self-checking bench for the status block.
module tb_instrument_status_event_registers;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg busy = 1'b0;
  reg lv = 1'b0;
  reg psc = 1'b1;
  reg [7:0] nv = 8'hFF;
  reg [8:0] ev = 9'h000;
  reg [1:0] kind = 2'h3;
  reg [15:0] ecode = 16'h0100;
  wire valid, ready, rv, ssum, qsum;
  wire [3:0] code;
  wire [15:0] arg, rsp;
  wire [4:0] eqc;
  wire [7:0] sb;
  wire pso, clp;
  wire [7:0] esm, srm;
  wire [15:0] qnm;
  integer cls_n = 0;
  integer bad_count = 0, num_checks = 0, cyc = 0, i;
  reg [15:0] q[$];
  // Clock of 25 ns.
  always #12.5 clk = ~clk;
  iser_ctrl_model m (.i_sys_clk(clk), .i_ready(ready), .i_rsp_valid(rv), .i_rsp_data(rsp), .o_valid(valid),
    .o_code(code), .o_arg(arg));
  iser_status dut (.i_sys_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_cmd_valid(valid), .i_cmd_code(code),
    .i_cmd_arg(arg), .o_cmd_ready(ready), .o_rsp_valid(rv), .o_rsp_data(rsp), .i_prior_busy(busy),
    .i_ev_empty_read(ev[0]), .i_ev_reply_overrun(ev[1]), .i_ev_bufs_full(ev[2]), .i_ev_dev_err(ev[3]),
    .i_ev_exec_err(ev[4]), .i_ev_cmd_err(ev[5]), .i_err_code(ecode), .i_ev_overload(ev[6]), .i_ovl_kind(kind),
    .i_ev_lim_lo(ev[7]), .i_ev_lim_hi(ev[8]), .i_mav(lv), .i_rqs(lv), .i_nv_psc(psc), .i_nv_ese(nv),
    .i_nv_sre(nv), .o_psc(pso), .o_ese_mask(esm), .o_sre_mask(srm), .o_ques_mask(qnm), .o_std_summary(ssum),
    .o_ques_summary(qsum), .o_status_byte(sb), .o_cls_pulse(clp), .o_eq_count(eqc));
  // Counts clear-status pulses seen on the port.
  always @(posedge clk) if (clp) cls_n = cls_n + 1;
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task qry(input [3:0] c, input [15:0] exp);
    reg [15:0] r;
    begin
      m.xfer(c, 16'h0000, 1'b1, r);
      chk(r, exp);
    end
  endtask
  task wr(input [3:0] c, input [15:0] a);
    reg [15:0] r;
    m.xfer(c, a, 1'b0, r);
  endtask
  // One-cycle event pulse; queued codes are mirrored, capped at the depth.
  task pulse(input [8:0] v, input [1:0] k);
    begin
      @(posedge clk);
      ev <= v;
      kind <= k;
      ecode <= ecode + 16'h0001;
      if (v[5:0] != 6'h00 && q.size() < 20) q.push_back(ecode + 16'h0001);
      @(posedge clk);
      ev <= 9'h000;
      kind <= 2'h3;
      repeat (2) @(negedge clk);
    end
  endtask
  task do_reset;
    begin
      @(posedge clk);
      rst <= 1'b1;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      q.delete();
    end
  endtask
  task endt(input string s);
    $display("test %0s done", s);
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  // Cuts a hang short.
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      bad_count = bad_count + 1;
      results;
    end
  end
  // Main sequence.
  initial begin
    do_reset;
    qry(`ISER_CMD_ESR_Q, 16'h0080);
    qry(`ISER_CMD_ESR_Q, 16'h0000);
    qry(`ISER_CMD_ESE_Q, 16'h0000);
    qry(`ISER_CMD_SRE_Q, 16'h0000);
    qry(`ISER_CMD_PSC_Q, 16'h0001);
    qry(`ISER_CMD_QEN_Q, 16'h0000);
    chk({8'h00, esm}, 16'h0000);
    chk({8'h00, srm}, 16'h0000);
    chk({15'h0000, pso}, 16'h0001);
    endt("power_on");
    wr(`ISER_CMD_ESE_W, 16'h003D);
    qry(`ISER_CMD_ESE_Q, 16'h003D);
    pulse(9'h020, 2'h3);
    chk({15'h0000, ssum}, 16'h0001);
    qry(`ISER_CMD_STB_Q, 16'h0020);
    qry(`ISER_CMD_ESR_Q, 16'h0020);
    for (i = 0; i < 5; i = i + 1) begin
      pulse(9'h001 << i, 2'h3);
      qry(`ISER_CMD_ESR_Q, i < 3 ? 16'h0004 : 16'h0001 << i);
    end
    chk({11'h000, eqc}, 16'(q.size()));
    endt("std_events");
    for (i = 0; i < 3; i = i + 1) pulse(9'h040, i[1:0]);
    pulse(9'h080, 2'h3);
    pulse(9'h100, 2'h3);
    qry(`ISER_CMD_QEV_Q, 16'h1A03);
    qry(`ISER_CMD_ESR_Q, 16'h0008);
    qry(`ISER_CMD_QEV_Q, 16'h0000);
    chk({11'h000, eqc}, 16'(q.size()));
    endt("overload");
    wr(`ISER_CMD_ESE_W, 16'h0001);
    @(posedge clk) busy <= 1'b1;
    wr(`ISER_CMD_OPC, 16'h0000);
    repeat (8) @(negedge clk);
    chk({15'h0000, ssum}, 16'h0000);
    @(posedge clk) busy <= 1'b0;
    qry(`ISER_CMD_OPC_Q, `ISER_OPC_REPLY);
    chk({15'h0000, ssum}, 16'h0001);
    qry(`ISER_CMD_ESR_Q, 16'h0001);
    endt("opc");
    pulse(9'h020, 2'h3);
    pulse(9'h040, 2'h0);
    wr(`ISER_CMD_CLS, 16'h0000);
    qry(`ISER_CMD_ESR_Q, 16'h0000);
    qry(`ISER_CMD_QEV_Q, 16'h0000);
    chk(cls_n[15:0], 16'h0001);
    endt("clear");
    wr(`ISER_CMD_QEN_W, 16'h1000);
    qry(`ISER_CMD_QEN_Q, 16'h1000);
    chk(qnm, 16'h1000);
    pulse(9'h100, 2'h3);
    chk({15'h0000, qsum}, 16'h0001);
    @(posedge clk) lv <= 1'b1;
    qry(`ISER_CMD_STB_Q, 16'h0058);
    qry(`ISER_CMD_STB_Q, 16'h0058);
    chk({8'h00, sb}, 16'h0058);
    wr(`ISER_CMD_PRESET, 16'h0000);
    qry(`ISER_CMD_QEN_Q, 16'h0000);
    chk(qnm, 16'h0000);
    wr(`ISER_CMD_SRE_W, 16'h00FF);
    qry(`ISER_CMD_SRE_Q, 16'h00BF);
    chk({8'h00, srm}, 16'h00BF);
    wr(`ISER_CMD_PSC_W, 16'h0000);
    qry(`ISER_CMD_PSC_Q, 16'h0000);
    chk({15'h0000, pso}, 16'h0000);
    endt("masks");
    for (i = 0; i < 20; i = i + 1) pulse(9'h010, 2'h3);
    chk({11'h000, eqc}, 16'h0014);
    for (i = 0; i < 20; i = i + 1) qry(`ISER_CMD_ERR_Q, q.pop_front());
    qry(`ISER_CMD_ERR_Q, `ISER_ERR_NONE);
    endt("queue");
    @(posedge clk);
    psc <= 1'b0;
    nv <= 8'h24;
    do_reset;
    qry(`ISER_CMD_ESE_Q, 16'h0024);
    qry(`ISER_CMD_SRE_Q, 16'h0024);
    qry(`ISER_CMD_QEN_Q, 16'h0000);
    qry(`ISER_CMD_ESR_Q, 16'h0080);
    chk({8'h00, esm}, 16'h0024);
    chk({8'h00, srm}, 16'h0024);
    endt("psc_off");
    results;
  end
endmodule
